/* File: hw/sfa_consts.svh */
`ifndef SFA_CONSTS_SVH
`define SFA_CONSTS_SVH

// Register byte offsets on the maintenance register bus.
`define REG_CTRL 8'h00
`define REG_SETPOINT 8'h04
`define REG_STATUS 8'h08
`define REG_OUTPUTS 8'h0c
`define REG_DIAG 8'h10

// Control register fields and reset values.
`define CTRL_HEATER_LSB 0
`define CTRL_NS_BLOCK_BIT 2
`define CTRL_RESET 32'h0000_0003
`define SETPOINT_RESET 16'hc000

// Timing: a safety bus refresh older than this marks the link stale.
`define CLK_PERIOD_NS 10
`define STALE_NS 2000
`define STALE_CYCLES (`STALE_NS / `CLK_PERIOD_NS)

// AXI response codes.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: hw/sfa_pkg.sv */
package sfa_pkg;

  // Command source that wins in the priority logic of one path.
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_AUTO,
    SRC_MANUAL,
    SRC_NONSAFETY
  } cmd_src_t;

  // Per-path drive to the actuated component; 1 means energized.
  typedef struct packed {
    logic [3:0] switches;
    logic heater_uv;
    logic heater_shunt_relay;
  } path_drive_t;

  // One-way monitoring data toward the nonsafety displays.
  typedef struct packed {
    logic [15:0] sensor_peak;
    logic fm_demand;
    logic division_act;
    logic [3:0] group_act;
    logic alarm_stale;
    logic [1:0] manual_seen;
  } monitor_t;

endpackage

/* File: hw/safety_actuation_voting_priority.sv */
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "sfa_consts.svh"
module safety_actuation_voting_priority
  import sfa_pkg::*;
#(
  parameter int SENSOR_W = 16,
  parameter int STALE_CNT = `STALE_CYCLES
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Maintenance register bus, AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Safety data buses: actuation bit and refresh toggle per group and bus.
  input wire logic [3:0][2:0] safety_data_bus_act,
  input wire logic [3:0][2:0] safety_data_bus_toggle,
  // Function module sensor inputs, already digitised.
  input wire logic [3:0][SENSOR_W-1:0] sensor_value,
  // Hard-wired manual initiation, one per path, and nonsafety control.
  input wire logic [1:0] manual_initiate,
  input wire logic [1:0] nonsafety_cmd_actuate,
  input wire logic nonsafety_permissive,
  // Function module decision on the three safety buses.
  output logic [2:0] fm_bus_act,
  // Component drive per path, 1 energized.
  output path_drive_t [1:0] path_drive,
  // One-way monitoring to nonsafety displays.
  output monitor_t monitor
);

  // Two-of-three majority, used for each group over its three buses.
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Two-or-more of four.
  function automatic logic two_of_four(input logic [3:0] v);
    logic [2:0] n;
    n = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
    two_of_four = (n >= 3'd2);
  endfunction

  localparam int CW = $clog2(STALE_CNT + 1);
  localparam int PW = 24 + 2 + 2 + 1 + 4 * SENSOR_W;

  // Two-stage synchroniser for every pin input other than the AXI4-Lite bus.
  logic [PW-1:0] pin_s1_r;
  logic [PW-1:0] pin_s2_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= {safety_data_bus_act, safety_data_bus_toggle, manual_initiate,
                   nonsafety_cmd_actuate, nonsafety_permissive, sensor_value};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [3:0][2:0] bus_act;
  logic [3:0][2:0] bus_tog;
  logic [1:0] manual_s;
  logic [1:0] ns_cmd_s;
  logic ns_permit_s;
  logic [3:0][SENSOR_W-1:0] sensor_s;
  // Split the synchronised vector back into its fields.
  assign {bus_act, bus_tog, manual_s, ns_cmd_s, ns_permit_s, sensor_s} = pin_s2_r;

  // Maintenance registers; ctrl_r gates the heaters and nonsafety control, setpoint_r sets the sensor trip level.
  logic [31:0] ctrl_r;
  logic [SENSOR_W-1:0] setpoint_r;
  logic [15:0] stale_events_r;

  // Refresh detection and staleness timers for each group and bus.
  logic [3:0][2:0] tog_prev_r;
  logic [3:0][2:0][CW-1:0] age_r;
  logic [3:0][2:0] stale_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tog_prev_r <= '0;
      age_r <= '0;
      stale_r <= '1;
    end
    else
    begin
      tog_prev_r <= bus_tog;
      for (int g = 0; g < 4; g++)
      begin
        for (int b = 0; b < 3; b++)
        begin
          if (bus_tog[g][b] != tog_prev_r[g][b])
          begin
            age_r[g][b] <= '0;
            stale_r[g][b] <= 1'b0;
          end
          else if (age_r[g][b] == CW'(STALE_CNT))
            stale_r[g][b] <= 1'b1;
          else
            age_r[g][b] <= age_r[g][b] + 1'b1;
        end
      end
    end
  end

  // Group demand: a stale bus counts as demanding, then 2oo3 over buses.
  logic [3:0] group_act;
  logic division_act;
  always_comb
  begin
    for (int g = 0; g < 4; g++)
      group_act[g] = maj3(bus_act[g] | stale_r[g]);
    division_act = two_of_four(group_act);
  end

  // Function module: any of four sensors at or above setpoint demands actuation.
  logic fm_demand;
  logic [SENSOR_W-1:0] peak;
  always_comb
  begin
    fm_demand = 1'b0;
    peak = '0;
    for (int s = 0; s < 4; s++)
    begin
      if (sensor_s[s] >= setpoint_r)
        fm_demand = 1'b1;
      if (sensor_s[s] > peak)
        peak = sensor_s[s];
    end
  end

  // Decision driven identically on all three safety buses.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fm_bus_act <= 3'h0;
    else
      fm_bus_act <= {3{fm_demand}};
  end

  // Priority logic per path: manual over automatic over nonsafety.
  cmd_src_t src [2];
  logic [1:0] actuate;
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (manual_s[p])
        src[p] = SRC_MANUAL;
      else if (division_act)
        src[p] = SRC_AUTO;
      else if (ns_permit_s && !ctrl_r[`CTRL_NS_BLOCK_BIT])
        src[p] = SRC_NONSAFETY;
      else
        src[p] = SRC_NONE;
      case (src[p])
        SRC_MANUAL: actuate[p] = 1'b1;
        SRC_AUTO: actuate[p] = 1'b1;
        SRC_NONSAFETY: actuate[p] = ns_cmd_s[p];
        SRC_NONE: actuate[p] = 1'b0;
        default: actuate[p] = 1'b1;
      endcase
    end
  end

  // Each path drives only its own component; reset holds all de-energized.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      path_drive <= '0;
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        path_drive[p].switches <= actuate[p] ? 4'h0 : 4'hf;
        if (ctrl_r[`CTRL_HEATER_LSB + p])
        begin
          // Heater paths follow this path's actuate: its manual switch, the division vote or a permitted nonsafety command.
          path_drive[p].heater_uv <= !actuate[p];
          path_drive[p].heater_shunt_relay <= !actuate[p];
        end
        else
        begin
          path_drive[p].heater_uv <= 1'b0;
          path_drive[p].heater_shunt_relay <= 1'b0;
        end
      end
    end
  end

  // Monitoring output is written from safety state and never read back.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      monitor <= '0;
    else
    begin
      monitor.sensor_peak <= peak;
      monitor.fm_demand <= fm_demand;
      monitor.division_act <= division_act;
      monitor.group_act <= group_act;
      monitor.alarm_stale <= |stale_r;
      monitor.manual_seen <= manual_s;
    end
  end

  // Counts cycles in which any link newly goes stale, for the maintenance workstation; saturates at 16'hffff.
  logic [3:0][2:0] stale_prev_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stale_prev_r <= '1;
      stale_events_r <= 16'h0000;
    end
    else
    begin
      stale_prev_r <= stale_r;
      if ((stale_r & ~stale_prev_r) != '0 && stale_events_r != 16'hffff)
        stale_events_r <= stale_events_r + 16'h0001;
    end
  end

  // AXI write channel: address and data taken in either order.
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (aw_held_r && w_held_r && !s_axi_bvalid)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (waddr_r == `REG_CTRL || waddr_r == `REG_SETPOINT) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Ready while nothing is held for that channel and no write response is pending.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Register updates with byte strobes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= `CTRL_RESET;
      setpoint_r <= SENSOR_W'(`SETPOINT_RESET);
    end
    else if (aw_held_r && w_held_r && !s_axi_bvalid)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wstrb_r[i] && waddr_r == `REG_CTRL)
          ctrl_r[8*i +: 8] <= (i == 0) ? (wdata_r[7:0] & 8'h07) : 8'h00;
      end
      if (waddr_r == `REG_SETPOINT)
      begin
        if (wstrb_r[0])
          setpoint_r[7:0] <= wdata_r[7:0];
        if (wstrb_r[1])
          setpoint_r[SENSOR_W-1:8] <= wdata_r[SENSOR_W-1:8];
      end
    end
  end

  // Read data mux; unmapped addresses answer zero with an error.
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL: rd_mux = ctrl_r;
      `REG_SETPOINT: rd_mux = 32'(setpoint_r);
      `REG_STATUS: rd_mux = {14'h0000, fm_demand, division_act, 4'(group_act), 12'(stale_r)};
      `REG_OUTPUTS: rd_mux = {20'h00000, 12'(path_drive)};
      `REG_DIAG: rd_mux = {16'h0000, stale_events_r};
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // AXI read channel: one read at a time, answer one cycle after acceptance.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // safety_actuation_voting_priority

/* File: testbench/safety_actuation_monitor.sv */
`timescale 1ns/1ns
module safety_actuation_monitor
  import sfa_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Watched inputs.
  input wire logic [1:0] manual_initiate,
  input wire logic nonsafety_permissive,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rready,
  // Watched outputs.
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0] fm_bus_act,
  input wire path_drive_t [1:0] path_drive,
  input wire monitor_t monitor
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Operator switch of path 0 held past the input synchroniser.
  sequence manual_held_s;
    manual_initiate[0] [*4];
  endsequence

  // No safety demand on path 0 and nonsafety control not permitted.
  sequence quiet_s;
    (!nonsafety_permissive && !manual_initiate[0] && !monitor.division_act) [*4];
  endsequence

  // Component drive, vote and bus handshakes.
  a_reset_safe: assert property (!$past(aresetn) |-> path_drive == '0)
    else $error("drive not safe after reset");
  a_vote_two_four: assert property (($countones(monitor.group_act) >= 2) == monitor.division_act)
    else $error("division vote wrong");
  a_act_opens_all: assert property (monitor.division_act |-> path_drive[0].switches == 4'h0 && path_drive[1].switches == 4'h0)
    else $error("actuation left switches closed");
  a_switch_group: assert property (path_drive[0].switches inside {4'h0, 4'hf})
    else $error("switches split");
  a_heater_pair: assert property (path_drive[1].heater_uv == path_drive[1].heater_shunt_relay && (!path_drive[1].heater_uv || path_drive[1].switches == 4'hf))
    else $error("heater outputs disagree");
  a_manual_wins: assert property (manual_held_s |-> path_drive[0].switches == 4'h0)
    else $error("manual switch ignored");
  a_nonsafety_gated: assert property (quiet_s |-> path_drive[0].switches == 4'hf)
    else $error("nonsafety acted without permissive");
  a_bus_copies: assert property (fm_bus_act inside {3'h0, 3'h7})
    else $error("bus copies differ");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule // safety_actuation_monitor

bind safety_actuation_voting_priority safety_actuation_monitor mon_u (.aclk, .aresetn, .manual_initiate,
  .nonsafety_permissive, .s_axi_arvalid, .s_axi_bready, .s_axi_rready, .s_axi_arready, .s_axi_bvalid,
  .s_axi_rvalid, .s_axi_rdata, .fm_bus_act, .path_drive, .monitor);

/* File: testbench/group_link_model.sv */
`timescale 1ns/1ns
module group_link_model (
  // Clock.
  input wire logic aclk,
  // Demand and link silence per group.
  input wire logic [3:0] demand,
  input wire logic [3:0] mute,
  // Safety bus lines toward the block.
  output logic [3:0][2:0] act,
  output logic [3:0][2:0] toggle
);
  logic [1:0] div_r;

  // Start with every group demanding and no refresh seen.
  initial
  begin
    div_r = 2'h0;
    act = '1;
    toggle = '0;
  end

  // Each group repeats its demand on three buses and refreshes every fourth cycle; a muted group goes stale.
  always @(posedge aclk)
  begin
    div_r <= div_r + 2'h1;
    for (int g = 0; g < 4; g++)
    begin
      act[g] <= {3{demand[g]}};
      if (div_r == 2'h0 && !mute[g])
      begin
        toggle[g] <= ~toggle[g];
      end
    end
  end
endmodule // group_link_model

/* File: testbench/safety_actuation_voting_priority_test.sv */
`timescale 1ns/1ns
`include "sfa_consts.svh"
module safety_actuation_voting_priority_test;
  import sfa_pkg::*;
  localparam int STALE = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0][2:0] bus_act, bus_tog;
  logic [3:0][15:0] sensor = '0;
  logic [1:0] manual = 2'h0, ns_cmd = 2'h0;
  logic ns_perm = 1'b0;
  logic [3:0] demand = 4'h0, mute = 4'h0;
  logic [2:0] fm_act;
  path_drive_t [1:0] drive;
  monitor_t mon;
  int num_errors = 0;
  int tests_run = 0;

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 aclk = ~aclk;
  end

  // Block under test and the far-side groups.
  safety_actuation_voting_priority #(.STALE_CNT(STALE)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .safety_data_bus_act(bus_act), .safety_data_bus_toggle(bus_tog),
    .sensor_value(sensor), .manual_initiate(manual), .nonsafety_cmd_actuate(ns_cmd),
    .nonsafety_permissive(ns_perm), .fm_bus_act(fm_act), .path_drive(drive), .monitor(mon));
  group_link_model model_u (.aclk(aclk), .demand(demand), .mute(mute), .act(bus_act), .toggle(bus_tog));

  // Compares one result and counts it.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write; address and data are released each at its own handshake.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_open || w_open)
    begin
      @(posedge aclk);
      if (aw_open && awready === 1'b1)
      begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready === 1'b1)
      begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
    end
    // Ready is raised only once the response stands, so a held response is exercised.
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b1;
    @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // Register read; ready is raised once the answer stands, so held read data is exercised.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Expected drive of one path.
  function automatic logic [5:0] pd(input logic off, input logic heat);
    return {off ? 4'h0 : 4'hf, {2{heat & !off}}};
  endfunction

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (num_errors == 0 && tests_run > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge aclk);
    check("drive", 32'h0, 32'(drive));
    aresetn <= 1'b1;
    repeat (40) @(posedge aclk);
    axi_read(`REG_CTRL, d, r);
    check("ctrl", `CTRL_RESET, d);
    axi_read(`REG_SETPOINT, d, r);
    check("setpoint", 32'(`SETPOINT_RESET), d);
    check("setpoint_rresp", 32'(`RESP_OKAY), 32'(r));
    axi_read(8'h40, d, r);
    check("hole_data", 32'h0, d);
    check("hole_rresp", 32'(`RESP_SLVERR), 32'(r));
    axi_write(8'h40, 32'hffff_ffff, r);
    check("hole_bresp", 32'(`RESP_SLVERR), 32'(r));
    for (int p = 0; p < 16; p++)
    begin
      demand <= p[3:0];
      repeat (8) @(posedge aclk);
      check("groups", 32'(p), 32'(mon.group_act));
      check("vote", 32'({2{pd($countones(p) >= 2, 1'b1)}}), 32'(drive));
    end
    demand <= 4'h0;
    mute <= 4'h1;
    repeat (STALE + 10) @(posedge aclk);
    check("one_stale", 32'hfff, 32'(drive));
    check("alarm", 32'h1, 32'(mon.alarm_stale));
    mute <= 4'h3;
    repeat (STALE + 10) @(posedge aclk);
    check("two_stale", 32'h0, 32'(drive));
    axi_read(`REG_STATUS, d, r);
    check("status", 32'h0001_303f, d);
    axi_read(`REG_DIAG, d, r);
    check("diag", 32'h2, d);
    mute <= 4'h0;
    manual <= 2'h1;
    repeat (STALE + 10) @(posedge aclk);
    check("manual", 32'hfc0, 32'(drive));
    check("manual_seen", 32'h1, 32'(mon.manual_seen));
    manual <= 2'h0;
    ns_cmd <= 2'h2;
    repeat (8) @(posedge aclk);
    check("ns_off", 32'hfff, 32'(drive));
    ns_perm <= 1'b1;
    repeat (8) @(posedge aclk);
    check("ns_on", 32'h03f, 32'(drive));
    axi_read(`REG_OUTPUTS, d, r);
    check("outputs", 32'h03f, d);
    axi_write(`REG_CTRL, 32'h7, r);
    check("ctrl_bresp", 32'(`RESP_OKAY), 32'(r));
    repeat (8) @(posedge aclk);
    check("ns_block", 32'hfff, 32'(drive));
    ns_cmd <= 2'h0;
    axi_write(`REG_CTRL, 32'h1, r);
    repeat (8) @(posedge aclk);
    check("heater_off", 32'hf3f, 32'(drive));
    sensor[2] <= 16'hc000;
    repeat (8) @(posedge aclk);
    check("fm_at_setpoint", 32'h7, 32'(fm_act));
    check("peak", 32'hc000, 32'(mon.sensor_peak));
    check("fm_flag", 32'h1, 32'(mon.fm_demand));
    axi_write(`REG_SETPOINT, 32'hc001, r);
    axi_read(`REG_SETPOINT, d, r);
    check("setpoint_new", 32'hc001, d);
    repeat (8) @(posedge aclk);
    check("fm_below", 32'h0, 32'(fm_act));
    final_report();
  end

  // Watchdog against a hung handshake.
  initial
  begin
    repeat (3000) @(posedge aclk);
    num_errors++;
    final_report();
  end
endmodule // safety_actuation_voting_priority_test
